/* File: rtl/ubrg_defs.vh */
// Constants for the baud rate generator: register map, field layout, reset values.
// Assumes inclusion by bare name from design files under rtl/ and from the bench under bench/.
`ifndef UBRG_DEFS_VH
`define UBRG_DEFS_VH
`define UBRG_ADDR_MODE 4'h0
`define UBRG_ADDR_DIV 4'h4
`define UBRG_ADDR_STAT 4'h8
`define UBRG_SRC_LSB 0
`define UBRG_SRC_MSB 1
`define UBRG_SYNC_BIT 2
`define UBRG_OVER_BIT 3
`define UBRG_OPMODE_LSB 4
`define UBRG_OPMODE_MSB 7
`define UBRG_SRC_PCLK 2'h0
`define UBRG_SRC_DIVCLK 2'h1
`define UBRG_SRC_EXT 2'h3
`define UBRG_PRESCALE 4'h8
`define UBRG_OVER8 5'h08
`define UBRG_OVER16 5'h10
`define UBRG_MODE_RST 32'h00000000
`define UBRG_DIV_RST 16'h0000
`define UBRG_RESP_OKAY 2'h0
`define UBRG_RESP_SLVERR 2'h2
`endif

/* File: rtl/ubrg_sync.v */
// Two-stage synchroniser for the external serial clock pin.
// Assumes the pin is asynchronous to clk; only stage two is read outside.
`timescale 1ns/1ps
module ubrg_sync (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Pin and synchronised level
  input wire pinIn,
  output reg pinSync
);
  reg stage1_r;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1_r <= 1'b0;
      pinSync <= 1'b0;
    end
    else
    begin
      stage1_r <= pinIn;
      pinSync <= stage1_r;
    end
  end
endmodule

/* File: rtl/ubrg_top.v */
// Baud rate generator with AXI4-Lite register access.
// Assumes one clock; the external serial clock is a pin sampled through a synchroniser.
//
// Behaviour
// [RULE1] Source: peripheral, prescaled, or external pin.
// [RULE2] Prescaled source divides peripheral clock by eight.
// [RULE3] Sixteen-bit divider uses clock divisor field.
// [RULE4] Divisor zero stops baud clock output, except sync mode on the external source.
// [RULE5] Divisor one bypasses divider entirely.
// [RULE6] External clock phases exceed one peripheral period.
// [RULE7] External clock under third, SPI sixth.
// [RULE8] Bit clock goes to receiver and transmitter.
// [RULE9] Async: divided clock samples, divided again for bits.
// [RULE10] Oversampling bit selects eight or sixteen.
// [RULE11] Bit rate is source over 8(2-over)divisor.
// [RULE12] Clock stop keeps all state intact.
// [RULE13] Source three external; sync on it ignores divisor.
// [RULE14] Outputs are enable pulses; pin synchronised.
`timescale 1ns/1ps
`include "ubrg_defs.vh"
module ubrg_top #(
  parameter DIV_W = 16
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // AXI4-Lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // External serial clock pin
  input wire serialClkIn,
  // Enables to receiver and transmitter
  output reg sampleTick_r,
  output reg bitTick_r
);
  reg [31:0] modeReg_r;
  reg [DIV_W-1:0] divReg_r;
  reg awHeld_r;
  reg wHeld_r;
  reg [3:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg [2:0] preCnt_r;
  reg [DIV_W-1:0] divCnt_r;
  reg [4:0] overCnt_r;
  reg extPrev_r;
  wire extSync;
  wire [1:0] srcSel;
  wire syncMode;
  wire overSel;
  wire [4:0] overLimit;
  wire preTick;
  wire extRise;
  reg srcTick;
  wire divTick;
  wire bitTickNxt;
  wire doWrite;
  wire wrAck;
  integer i;

  // Pin level is only read after the second stage; see [RULE14]
  ubrg_sync uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(serialClkIn),
    .pinSync(extSync)
  );

  assign srcSel = modeReg_r[`UBRG_SRC_MSB:`UBRG_SRC_LSB];
  assign syncMode = modeReg_r[`UBRG_SYNC_BIT];
  assign overSel = modeReg_r[`UBRG_OVER_BIT];
  // Edges are seen on the sampled pin; fast external clocks would alias, see [RULE6] [RULE7].
  assign extRise = extSync & ~extPrev_r;

  // Fixed prescaler, free running so the source has a steady phase; see [RULE2]
  assign preTick = (preCnt_r == (`UBRG_PRESCALE - 4'h1));

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      preCnt_r <= 3'h0;
      extPrev_r <= 1'b0;
    end
    else
    begin
      preCnt_r <= preCnt_r + 3'h1;
      extPrev_r <= extSync;
    end
  end

  // Source select as a per-cycle enable; see [RULE1] [RULE13]
  always @*
  begin
    case (srcSel)
      `UBRG_SRC_PCLK:
      begin
        srcTick = 1'b1;
      end
      `UBRG_SRC_DIVCLK:
      begin
        srcTick = preTick;
      end
      `UBRG_SRC_EXT:
      begin
        // One enable per pin period; the pin is never used as a clock net.
        srcTick = extRise;
      end
      default:
      begin
        // The unused code is kept silent rather than aliased to a source.
        srcTick = 1'b0;
      end
    endcase
  end

  // Divider: zero gives nothing, one passes the source through; see [RULE3] [RULE4] [RULE5]
  assign divTick = srcTick && (divReg_r != {DIV_W{1'b0}}) &&
                   ((divReg_r == {{(DIV_W-1){1'b0}}, 1'b1}) ||
                    (divCnt_r == divReg_r - {{(DIV_W-1){1'b0}}, 1'b1}));

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      divCnt_r <= {DIV_W{1'b0}};
    end
    else if (divReg_r == {DIV_W{1'b0}})
    begin
      // Parked at zero so a later nonzero divisor starts a full period.
      divCnt_r <= {DIV_W{1'b0}};
    end
    else if (divTick)
    begin
      divCnt_r <= {DIV_W{1'b0}};
    end
    else if (srcTick)
    begin
      divCnt_r <= divCnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // Oversampling divide by 8 or 16 in async mode; see [RULE10] [RULE11]
  assign overLimit = overSel ? `UBRG_OVER8 : `UBRG_OVER16;
  assign bitTickNxt = syncMode ?
                      ((srcSel == `UBRG_SRC_EXT) ? extRise : divTick) :
                      (divTick && (overCnt_r == overLimit - 5'h01));

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      overCnt_r <= 5'h00;
    end
    else if (syncMode)
    begin
      overCnt_r <= 5'h00;
    end
    else if (divTick)
    begin
      // The compare is at-or-above so a switch from 16 to 8 cannot overrun.
      overCnt_r <= (overCnt_r >= overLimit - 5'h01) ? 5'h00 : overCnt_r + 5'h01;
    end
  end

  // Enables leave straight from flops to both receiver and transmitter; see [RULE8] [RULE9]
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sampleTick_r <= 1'b0;
      bitTick_r <= 1'b0;
    end
    else
    begin
      sampleTick_r <= syncMode ? bitTickNxt : divTick;
      bitTick_r <= bitTickNxt;
    end
  end

  // Bus slave. Counters only move on clock edges, so a stopped clock freezes
  // everything in place and a restart resumes exactly; see [RULE12]
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wrAck = s_axi_bvalid && s_axi_bready;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UBRG_RESP_OKAY;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 4'h0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      modeReg_r <= `UBRG_MODE_RST;
      divReg_r <= `UBRG_DIV_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `UBRG_RESP_OKAY;
        if (awAddr_r == `UBRG_ADDR_MODE)
        begin
          for (i = 0; i < 4; i = i + 1)
            if (wStrb_r[i])
              modeReg_r[i*8 +: 8] <= wData_r[i*8 +: 8];
        end
        else if (awAddr_r == `UBRG_ADDR_DIV)
        begin
          for (i = 0; i < 2; i = i + 1)
            if (wStrb_r[i])
              divReg_r[i*8 +: 8] <= wData_r[i*8 +: 8];
        end
        else
          s_axi_bresp <= `UBRG_RESP_SLVERR;
      end
      if (wrAck)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `UBRG_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `UBRG_RESP_OKAY;
      case (s_axi_araddr)
        `UBRG_ADDR_MODE:
        begin
          s_axi_rdata <= modeReg_r;
        end
        `UBRG_ADDR_DIV:
        begin
          s_axi_rdata <= {{(32-DIV_W){1'b0}}, divReg_r};
        end
        `UBRG_ADDR_STAT:
        begin
          // Live counters; a read is a snapshot and may lag the ticks by a cycle.
          s_axi_rdata <= {{(27-DIV_W){1'b0}}, divCnt_r, overCnt_r};
        end
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `UBRG_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* File: bench/ubrg_props.sv */
// Checker for the baud rate generator: bus handshakes and tick relations.
// Assumes it is bound into ubrg_top and sees only that module's ports.
`timescale 1ns/1ps
module ubrg_props (
  // Clock and reset
  input wire logic clk, sys_rst,
  // Register bus
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  // Enables
  input wire logic sampleTick_r, bitTick_r
);
  reg divZero_r;
  reg [2:0] zeroCnt_r;
  reg syncExt_r;
  wire wrDiv = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_awaddr == 4'h4;
  wire wrMode = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_awaddr == 4'h0;
  // Writes arrive with address and data together, so one edge sees both.
  always @(posedge clk)
  begin
    if (sys_rst) divZero_r <= 1'h1;
    else if (wrDiv) divZero_r <= s_axi_wdata[15:0] == 16'h0;
    // Sync mode on the pin ignores the divisor, so zero still ticks there.
    if (sys_rst) syncExt_r <= 1'h0;
    else if (wrMode) syncExt_r <= s_axi_wdata[2:0] == 3'h7;
    if (sys_rst || wrDiv || wrMode || syncExt_r || !divZero_r) zeroCnt_r <= 3'h0;
    else if (zeroCnt_r != 3'h7) zeroCnt_r <= zeroCnt_r + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_zero; zeroCnt_r == 3'h7 |-> !sampleTick_r && !bitTick_r; endproperty
  a_zero: assert property (p_zero) else $error("tick with zero divisor");
  property p_bit; bitTick_r |-> sampleTick_r; endproperty
  a_bit: assert property (p_bit) else $error("bit tick off sample");
  property p_aw; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw: assert property (p_aw) else $error("awready stayed high");
  property p_b; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b: assert property (p_b) else $error("late write response");
  property p_bh; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
  a_bh: assert property (p_bh) else $error("write not closed");
  property p_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_r: assert property (p_r) else $error("late read data");
  property p_rh; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_rh: assert property (p_rh) else $error("read not closed");
  property p_err; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error read with data");
  c_bit: cover property (bitTick_r);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_zero: cover property (zeroCnt_r == 3'h7);
endmodule
bind ubrg_top ubrg_props u_props (.*);

/* File: bench/ubrg_ext_clk.sv */
// Remote device model driving the external serial clock pin.
// Assumes the bench raises run only while a clocked transfer is wanted.
`timescale 1ns/1ps
module ubrg_ext_clk #(
  parameter HALF_NS = 20
) (
  // Control
  input wire logic run,
  // Serial clock pin
  output logic sck
);
  // The 3 ns offset keeps pin edges off the peripheral clock edge.
  initial
  begin
    sck = 1'h0;
    #3;
    forever #HALF_NS sck = run ? ~sck : 1'h0;
  end
endmodule

/* File: bench/usart_baud_rate_generator_tb.sv */
// Bench for the baud rate generator: register, divider and external clock tests.
// Assumes ubrg_top, the external clock model and the checker are compiled first.
`timescale 1ns/1ps
`include "ubrg_defs.vh"
module usart_baud_rate_generator_tb;
  logic clk = 1'h0, sys_rst = 1'h1, extRun = 1'h0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, c, s;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic serialClkIn, sampleTick_r, bitTick_r;
  int n_mismatch = 0, checks_done = 0;
  ubrg_top DUT (.*);
  ubrg_ext_clk uExt (.run(extRun), .sck(serialClkIn));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, (a == `UBRG_ADDR_MODE || a == `UBRG_ADDR_DIV) ?
        `UBRG_RESP_OKAY : `UBRG_RESP_SLVERR);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, a == 4'hc ? `UBRG_RESP_SLVERR : `UBRG_RESP_OKAY);
  endtask
  task automatic cfg(input logic [1:0] src, input logic y, o, input logic [15:0] dv);
    wr(`UBRG_ADDR_DIV, {16'h0, dv});
    wr(`UBRG_ADDR_MODE, {28'h0, o, y, src});
  endtask
  // Measures one bit period twice so a period left over from the old setting is dropped.
  task automatic per;
    repeat (2)
    begin
      c = '0;
      s = '0;
      do @(posedge clk); while (bitTick_r !== 1'h1);
      do
      begin
        @(posedge clk);
        c++;
        s += {31'h0, sampleTick_r};
      end
      while (bitTick_r !== 1'h1);
    end
  endtask
  task automatic quiet;
    s = '0;
    repeat (64) @(posedge clk) s += {31'h0, sampleTick_r | bitTick_r};
    chk(s, 32'h0);
  endtask
  task automatic t_regs;
    rdc(`UBRG_ADDR_MODE, `UBRG_MODE_RST);
    rdc(`UBRG_ADDR_DIV, {16'h0, `UBRG_DIV_RST});
    quiet;
    wr(`UBRG_ADDR_DIV, 32'h0000fffe);
    rdc(`UBRG_ADDR_DIV, 32'h0000fffe);
    wr(4'hc, 32'h00001234);
    wr(`UBRG_ADDR_STAT, 32'h00005678);
    rdc(`UBRG_ADDR_DIV, 32'h0000fffe);
    rdc(4'hc, 32'h0);
    $display("register test done");
  endtask
  task automatic t_async;
    for (int i = 0; i < 8; i++)
    begin
      cfg(i[0] ? `UBRG_SRC_DIVCLK : `UBRG_SRC_PCLK, 1'h0, i[1], i[2] ? 16'h3 : 16'h1);
      per;
      chk(s, i[1] ? 8 : 16);
      chk(c, (i[0] ? 8 : 1) * (i[1] ? 8 : 16) * (i[2] ? 3 : 1));
    end
    $display("async test done");
  endtask
  task automatic t_sync;
    cfg(`UBRG_SRC_PCLK, 1'h1, 1'h0, 16'h5);
    per;
    chk(c, 32'h5);
    extRun <= 1'h1;
    cfg(`UBRG_SRC_EXT, 1'h1, 1'h0, 16'h7);
    per;
    chk(c, 32'h5);
    cfg(`UBRG_SRC_EXT, 1'h0, 1'h1, 16'h1);
    per;
    chk(c, 32'h28);
    wr(`UBRG_ADDR_DIV, 32'h0);
    quiet;
    extRun <= 1'h0;
    $display("sync and external test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    t_regs;
    t_async;
    t_sync;
    close_out;
  end
  initial
  begin
    #400000;
    n_mismatch++;
    close_out;
  end
endmodule
